/* File: hdl/icp_pkg.sv */
package icp_pkg;
   // ****************************************************************
   // Register indices on the plain register port.
   // ****************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CORE_FLAG = 4'h1;
   localparam logic [3:0] REG_CORE_EN = 4'h2;
   localparam logic [3:0] REG_CORE_PRIO = 4'h3;
   localparam logic [3:0] REG_EDGE = 4'h4;
   localparam logic [3:0] REG_PERI_FLAG = 4'h5;
   localparam logic [3:0] REG_PERI_EN = 4'h6;
   localparam logic [3:0] REG_PERI_PRIO = 4'h7;
   localparam logic [3:0] REG_PORT = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'h9;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int CTRL_PRIO_MODE_BIT = 0;
   localparam int CTRL_GLOBAL_BIT = 1;
   localparam int CTRL_PERI_LOW_BIT = 2;
   localparam int STAT_IN_HIGH_BIT = 0;
   localparam int STAT_IN_LOW_BIT = 1;
   localparam int CORE_PORT_BIT = 3;

   // ****************************************************************
   // Widths, reset values and vectors.
   // ****************************************************************
   localparam int CORE_W = 4;
   localparam int PERI_W = 8;
   localparam int EXT_W = 3;
   localparam int PORT_W = 4;
   localparam logic [CORE_W-1:0] CORE_PRIO_RST = 4'hf;
   localparam logic [PERI_W-1:0] PERI_PRIO_RST = 8'hff;
   localparam logic [EXT_W-1:0] EDGE_RST = 3'h7;
   localparam logic [15:0] HIGH_VECTOR = 16'h0008;
   localparam logic [15:0] LOW_VECTOR = 16'h0018;
endpackage : icp_pkg

/* File: hdl/icp_flag_bank.sv */
`timescale 1ns/100ps
module icp_flag_bank #(
   parameter int W = 8,
   parameter logic [W-1:0] PRIO_RST = '1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] set_evt,
   input wire logic wr_flag,
   input wire logic wr_en,
   input wire logic wr_prio,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] flag_q,
   output logic [W-1:0] en_q,
   output logic [W-1:0] prio_q
);
   logic [W-1:0] flag_d;
   logic [W-1:0] en_d;
   logic [W-1:0] prio_d;

   // ****************************************************************
   // Flag, enable and priority bits of each source.
   // ****************************************************************
   always_comb begin
      flag_d = wr_flag ? wdata : flag_q;
      // An event in the cycle of a software clear still sets the flag.
      flag_d = flag_d | set_evt; // [RULE16]
      en_d = wr_en ? wdata : en_q;
      prio_d = wr_prio ? wdata : prio_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin // [RULE3]
      if (!rst_n) begin
         flag_q <= '0;
         en_q <= '0;
         prio_q <= PRIO_RST;
      end else begin
         flag_q <= flag_d;
         en_q <= en_d;
         prio_q <= prio_d;
      end
   end
endmodule : icp_flag_bank

/* File: hdl/icp_ctrl.sv */
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Contract
// RULE1: Priority mode vectors high requests to 0008h, low ones to 0018h.
// RULE2: An enabled high request preempts a running low service routine.
// RULE3: Every source owns a flag, an enable and a priority select bit.
// RULE4: Priority mode only when software sets the mode bit; reset clears it.
// RULE5: Priority selects are ignored in compatibility mode.
// RULE6: Compatibility mode vectors every accepted interrupt to 0008h.
// RULE7: Compat: peripheral enable gates peripherals, global enable gates all.
// RULE8: Priority mode: high global enable admits high sources, blocks all.
// RULE9: Low global enable gates low sources, also needing the high enable.
// RULE10: Flag, enable and global enable all set means vector at once.
// RULE11: Accepting an interrupt clears the global enable of its level.
// RULE12: No low request is accepted while a high routine runs.
// RULE13: Entry pushes the return address and loads the vector.
// RULE14: Return from routine re-sets the matching global enable.
// RULE15: Pin and port-change latency is three to four instruction cycles.
// RULE16: Flags set on events regardless of any enable.
// RULE17: Software clears a flag before re-enabling, else it repeats.
// RULE18: Software avoids memory-to-memory moves on these registers.
// RULE19: Each external pin has a rising or falling edge select.
// RULE20: Port change flag keeps setting until the port is read.
// RULE21: High and low eligible together: high is served first.
module icp_ctrl (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   input wire logic [icp_pkg::PERI_W-1:0] peri_event,
   input wire logic [icp_pkg::EXT_W-1:0] ext_pin,
   input wire logic [icp_pkg::PORT_W-1:0] port_pin,
   input wire logic instr_boundary,
   input wire logic [15:0] return_addr,
   input wire logic return_from_isr_instr,
   output logic irq_take_q,
   output logic [15:0] vector_addr_q,
   output logic stack_push_q,
   output logic [15:0] stack_data_q,
   output logic isr_high_q,
   output logic isr_low_q
);
   // ****************************************************************
   // Reset release and pin synchronisers.
   // ****************************************************************
   logic rs1_q;
   logic rst_n;
   logic [icp_pkg::EXT_W-1:0] ext_s1_q, ext_s2_q, ext_prev_q;
   logic [icp_pkg::PORT_W-1:0] port_s1_q, port_s2_q, snap_q, snap_d;
   logic snap_ok_q;
   logic [icp_pkg::EXT_W-1:0] edge_q, edge_d, ext_evt;
   logic mismatch;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction : hit

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rs1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_n <= rs1_q;
      end
   end

   always_comb begin
      edge_d = (reg_wr && hit(reg_addr, icp_pkg::REG_EDGE)) ?
               reg_wdata[icp_pkg::EXT_W-1:0] : edge_q;
      snap_d = (reg_rd && hit(reg_addr, icp_pkg::REG_PORT)) ?
               port_s2_q : snap_q; // [RULE20]
      if (!snap_ok_q) begin
         snap_d = port_s2_q;
      end
   end

   // Two flops on each pin plus the flag flop keep the pin-to-flag
   // path at three clocks, three instruction cycles when every clock is a boundary.
   always_ff @(posedge clk or negedge rst_n) begin // [RULE15]
      if (!rst_n) begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
         ext_prev_q <= '0;
         port_s1_q <= '0;
         port_s2_q <= '0;
         snap_q <= '0;
         snap_ok_q <= 1'b0;
         edge_q <= icp_pkg::EDGE_RST;
      end else begin
         ext_s1_q <= ext_pin;
         ext_s2_q <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
         port_s1_q <= port_pin;
         port_s2_q <= port_s1_q;
         snap_q <= snap_d;
         snap_ok_q <= 1'b1;
         edge_q <= edge_d;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < icp_pkg::EXT_W; gi++) begin : g_edge
         assign ext_evt[gi] = edge_q[gi] ?
            (ext_s2_q[gi] & ~ext_prev_q[gi]) :
            (~ext_s2_q[gi] & ext_prev_q[gi]); // [RULE19]
      end
   endgenerate

   assign mismatch = snap_ok_q && (port_s2_q != snap_q); // [RULE20]

   // ****************************************************************
   // Source banks.
   // ****************************************************************
   logic [icp_pkg::CORE_W-1:0] cflag, cen, cprio, core_act;
   logic [icp_pkg::PERI_W-1:0] pflag, pen, pprio, peri_act;

   icp_flag_bank #(
      .W(icp_pkg::CORE_W),
      .PRIO_RST(icp_pkg::CORE_PRIO_RST)
   ) u_core (
      .clk(clk),
      .rst_n(rst_n),
      .set_evt({mismatch, ext_evt}),
      .wr_flag(reg_wr && hit(reg_addr, icp_pkg::REG_CORE_FLAG)),
      .wr_en(reg_wr && hit(reg_addr, icp_pkg::REG_CORE_EN)),
      .wr_prio(reg_wr && hit(reg_addr, icp_pkg::REG_CORE_PRIO)),
      .wdata(reg_wdata[icp_pkg::CORE_W-1:0]),
      .flag_q(cflag),
      .en_q(cen),
      .prio_q(cprio)
   );

   icp_flag_bank #(
      .W(icp_pkg::PERI_W),
      .PRIO_RST(icp_pkg::PERI_PRIO_RST)
   ) u_peri (
      .clk(clk),
      .rst_n(rst_n),
      .set_evt(peri_event),
      .wr_flag(reg_wr && hit(reg_addr, icp_pkg::REG_PERI_FLAG)),
      .wr_en(reg_wr && hit(reg_addr, icp_pkg::REG_PERI_EN)),
      .wr_prio(reg_wr && hit(reg_addr, icp_pkg::REG_PERI_PRIO)),
      .wdata(reg_wdata),
      .flag_q(pflag),
      .en_q(pen),
      .prio_q(pprio)
   );

   // ****************************************************************
   // Request arbitration.
   // ****************************************************************
   logic pme_q, gh_q, gl_q, pme_d, gh_d, gl_d, in_hi_d, in_lo_d;
   logic compat_req, hi_req, lo_req, take_hi, take_lo;

   assign core_act = cflag & cen;
   assign peri_act = pflag & pen;
   assign compat_req = gh_q & (|core_act | (gl_q & |peri_act)); // [RULE7]
   assign hi_req = gh_q & (|(core_act & cprio) | |(peri_act & pprio));
   assign lo_req = gh_q & gl_q &
                   (|(core_act & ~cprio) | |(peri_act & ~pprio)); // [RULE9]
   // Compatibility mode takes no notice of the priority selects.
   assign take_hi = instr_boundary &
                    (pme_q ? hi_req : compat_req); // [RULE5] [RULE8]
   // A low request yields to a high one eligible in the same cycle.
   assign take_lo = instr_boundary & pme_q & lo_req & ~hi_req &
                    ~isr_high_q; // [RULE12] [RULE21]

   always_comb begin
      pme_d = pme_q;
      gh_d = gh_q;
      gl_d = gl_q;
      in_hi_d = isr_high_q;
      in_lo_d = isr_low_q;
      if (reg_wr && hit(reg_addr, icp_pkg::REG_CTRL)) begin
         pme_d = reg_wdata[icp_pkg::CTRL_PRIO_MODE_BIT]; // [RULE4]
         gh_d = reg_wdata[icp_pkg::CTRL_GLOBAL_BIT];
         gl_d = reg_wdata[icp_pkg::CTRL_PERI_LOW_BIT];
      end
      if (return_from_isr_instr) begin // [RULE14]
         // In compatibility mode one return closes whichever routine ran.
         if (!pme_q) begin
            gh_d = 1'b1;
            in_hi_d = 1'b0;
            in_lo_d = 1'b0;
         end else if (isr_high_q) begin
            gh_d = 1'b1;
            in_hi_d = 1'b0;
         end else begin
            gl_d = 1'b1;
            in_lo_d = 1'b0;
         end
      end
      if (take_hi) begin // [RULE11] [RULE2]
         gh_d = 1'b0;
         in_hi_d = 1'b1;
      end else if (take_lo) begin
         gl_d = 1'b0;
         in_lo_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pme_q <= 1'b0;
         gh_q <= 1'b0;
         gl_q <= 1'b0;
         isr_high_q <= 1'b0;
         isr_low_q <= 1'b0;
      end else begin
         pme_q <= pme_d;
         gh_q <= gh_d;
         gl_q <= gl_d;
         isr_high_q <= in_hi_d;
         isr_low_q <= in_lo_d;
      end
   end

   // ****************************************************************
   // Vectoring and register read-back.
   // ****************************************************************
   logic take_d, push_d;
   logic [15:0] vec_d, sdata_d;
   logic [7:0] rdata_d;

   always_comb begin
      take_d = take_hi | take_lo; // [RULE10]
      push_d = take_hi | take_lo; // [RULE13]
      sdata_d = (take_hi | take_lo) ? return_addr : stack_data_q;
      vec_d = vector_addr_q;
      if (take_hi) begin
         vec_d = icp_pkg::HIGH_VECTOR; // [RULE1] [RULE6]
      end else if (take_lo) begin
         vec_d = icp_pkg::LOW_VECTOR; // [RULE1]
      end
      rdata_d = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            icp_pkg::REG_CTRL: begin
               rdata_d[icp_pkg::CTRL_PRIO_MODE_BIT] = pme_q;
               rdata_d[icp_pkg::CTRL_GLOBAL_BIT] = gh_q;
               rdata_d[icp_pkg::CTRL_PERI_LOW_BIT] = gl_q;
            end
            icp_pkg::REG_CORE_FLAG: rdata_d[icp_pkg::CORE_W-1:0] = cflag;
            icp_pkg::REG_CORE_EN: rdata_d[icp_pkg::CORE_W-1:0] = cen;
            icp_pkg::REG_CORE_PRIO: rdata_d[icp_pkg::CORE_W-1:0] = cprio;
            icp_pkg::REG_EDGE: rdata_d[icp_pkg::EXT_W-1:0] = edge_q;
            icp_pkg::REG_PERI_FLAG: rdata_d = pflag;
            icp_pkg::REG_PERI_EN: rdata_d = pen;
            icp_pkg::REG_PERI_PRIO: rdata_d = pprio;
            icp_pkg::REG_PORT: rdata_d[icp_pkg::PORT_W-1:0] = port_s2_q;
            icp_pkg::REG_STATUS: begin
               rdata_d[icp_pkg::STAT_IN_HIGH_BIT] = isr_high_q;
               rdata_d[icp_pkg::STAT_IN_LOW_BIT] = isr_low_q;
            end
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_take_q <= 1'b0;
         stack_push_q <= 1'b0;
         vector_addr_q <= 16'h0000;
         stack_data_q <= 16'h0000;
         reg_rdata_q <= 8'h00;
      end else begin
         irq_take_q <= take_d;
         stack_push_q <= push_d;
         vector_addr_q <= vec_d;
         stack_data_q <= sdata_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   low_vector_a: assert property ( // [RULE1]
      take_lo |=> irq_take_q && vector_addr_q == icp_pkg::LOW_VECTOR)
      else $error("low request did not vector to the low address");
   compat_vector_a: assert property ( // [RULE6]
      irq_take_q && !$past(pme_q) |-> vector_addr_q == icp_pkg::HIGH_VECTOR)
      else $error("compatibility vector is not the high address");
   preempt_low_a: assert property ( // [RULE2]
      isr_low_q && pme_q && hi_req && instr_boundary |=>
      irq_take_q && vector_addr_q == icp_pkg::HIGH_VECTOR && isr_high_q)
      else $error("high request did not preempt low routine");
   compat_noprio_a: assert property ( // [RULE5]
      !pme_q |-> !take_lo)
      else $error("low level taken in compatibility mode");
   peri_gate_a: assert property ( // [RULE7]
      take_hi && !pme_q && !(|core_act) |-> gl_q && gh_q)
      else $error("peripheral taken without both enables");
   high_gate_a: assert property ( // [RULE8]
      irq_take_q |-> $past(gh_q))
      else $error("interrupt taken with high global enable clear");
   low_gate_a: assert property ( // [RULE9]
      take_lo |-> gh_q && gl_q && !hi_req)
      else $error("low request taken without both enables");
   take_now_a: assert property ( // [RULE10]
      instr_boundary && (pme_q ? hi_req || lo_req && !isr_high_q
                               : compat_req) |=> irq_take_q)
      else $error("eligible request was not vectored");
   enable_clear_a: assert property ( // [RULE11]
      take_hi |=> !gh_q ##1 !gh_q || $past(reg_wr) ||
                  $past(return_from_isr_instr))
      else $error("global enable not cleared on acceptance");
   high_block_a: assert property ( // [RULE12]
      isr_high_q |-> !take_lo)
      else $error("low request accepted during high routine");
   push_addr_a: assert property ( // [RULE13]
      irq_take_q |-> stack_push_q && stack_data_q == $past(return_addr))
      else $error("return address not pushed on entry");
   return_enable_a: assert property ( // [RULE14]
      return_from_isr_instr && !take_hi && !take_lo && !reg_wr &&
      (!pme_q || isr_high_q) |=> gh_q)
      else $error("return did not restore the global enable");
   port_flag_a: assert property ( // [RULE20]
      mismatch [*2] |-> cflag[icp_pkg::CORE_PORT_BIT] [*2])
      else $error("port change flag not held during mismatch");
   edge_flag_a: assert property ( // [RULE19]
      ext_evt[0] |=> cflag[0])
      else $error("selected edge did not set the pin flag");
   pin_latency_a: assert property ( // [RULE15]
      $rose(ext_s2_q[0]) && edge_q[0] |=> cflag[0])
      else $error("pin edge reached its flag late");
   return_low_a: assert property ( // [RULE14]
      return_from_isr_instr && pme_q && !isr_high_q && !take_lo &&
      !reg_wr |=> gl_q)
      else $error("return did not restore the low global enable");
   flag_poll_a: assert property ( // [RULE16]
      peri_event[0] |=> pflag[0])
      else $error("peripheral event did not set its flag");
   port_read_a: assert property ( // [RULE20]
      reg_rd && hit(reg_addr, icp_pkg::REG_PORT) ##1 $stable(port_s2_q)
      |-> !mismatch)
      else $error("port read did not end the mismatch");
endmodule : icp_ctrl

/* File: dv/icp_core_model.sv */
`timescale 1ns/100ps
module icp_core_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic boundary_en,
   input wire logic ret_req,
   input wire logic irq_take_q,
   input wire logic [15:0] vector_addr_q,
   output logic instr_boundary,
   output logic [15:0] return_addr,
   output logic return_from_isr_instr,
   output logic [15:0] ra_seen_q
);
   logic [15:0] pc_q;
   logic [15:0] stack_q [0:7];
   logic [2:0] sp_q;
   // ****************************************************************
   // Fetch, stack and return.
   // ****************************************************************
   assign instr_boundary = boundary_en;
   assign return_addr = pc_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= 16'h0100;
         ra_seen_q <= 16'h0000;
         return_from_isr_instr <= 1'b0;
         sp_q <= 3'h0;
      end else begin
         // In the cycle after an accept this holds the interrupted address.
         ra_seen_q <= return_addr;
         return_from_isr_instr <= ret_req;
         if (irq_take_q) begin
            stack_q[sp_q] <= ra_seen_q;
            sp_q <= sp_q + 3'h1;
            pc_q <= vector_addr_q;
         end else if (return_from_isr_instr) begin
            pc_q <= stack_q[sp_q - 3'h1];
            sp_q <= sp_q - 3'h1;
         end else if (instr_boundary) begin
            pc_q <= pc_q + 16'h0001;
         end
      end
   end
endmodule : icp_core_model

/* File: dv/tb_icp_ctrl.sv */
`timescale 1ns/100ps
module tb_icp_ctrl;
   logic clk, reset_n, reg_wr, reg_rd, instr_boundary;
   logic return_from_isr_instr;
   logic irq_take_q, stack_push_q, isr_high_q, isr_low_q;
   logic boundary_en, ret_req;
   logic [3:0] reg_addr, port_pin;
   logic [7:0] reg_wdata, reg_rdata_q, peri_event;
   logic [2:0] ext_pin;
   logic [15:0] return_addr, vector_addr_q, stack_data_q, ra_seen_q;
   int n_errors, n_compared;
   icp_ctrl icp_ctrl_inst (.clk(clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .peri_event(peri_event),
      .ext_pin(ext_pin), .port_pin(port_pin),
      .instr_boundary(instr_boundary), .return_addr(return_addr),
      .return_from_isr_instr(return_from_isr_instr),
      .irq_take_q(irq_take_q),
      .vector_addr_q(vector_addr_q), .stack_push_q(stack_push_q),
      .stack_data_q(stack_data_q), .isr_high_q(isr_high_q),
      .isr_low_q(isr_low_q));
   icp_core_model icp_core_model_inst (.clk(clk), .rst_n(reset_n),
      .boundary_en(boundary_en), .ret_req(ret_req),
      .irq_take_q(irq_take_q), .vector_addr_q(vector_addr_q),
      .instr_boundary(instr_boundary), .return_addr(return_addr),
      .return_from_isr_instr(return_from_isr_instr),
      .ra_seen_q(ra_seen_q));
   always #12.5 clk = ~clk;
   // ****************************************************************
   // Access tasks.
   // ****************************************************************
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      // Each write touches one register; no memory-to-memory moves.
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", {8'h00, e}, {8'h00, reg_rdata_q});
   endtask : rd
   task automatic ev(input logic [7:0] m);
      @(posedge clk);
      peri_event <= m;
      @(posedge clk);
      peri_event <= 8'h00;
   endtask : ev
   task automatic ret();
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask : ret
   task automatic none(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         chk("no_take", 16'h0000, {15'h0000, irq_take_q});
      end
   endtask : none
   task automatic take(input logic [15:0] v, input int lim);
      int i;
      logic lvl;
      i = 0;
      #1;
      while (irq_take_q !== 1'b1 && i < lim) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk("take", 16'h0001, {15'h0000, irq_take_q});
      chk("push", 16'h0001, {15'h0000, stack_push_q});
      chk("vector", v, vector_addr_q);
      chk("stack", ra_seen_q, stack_data_q);
      lvl = (v == icp_pkg::HIGH_VECTOR) ? isr_high_q : isr_low_q;
      chk("level", 16'h0001, {15'h0000, lvl});
   endtask : take
   // ****************************************************************
   // Main sequence and watchdog.
   // ****************************************************************
   initial begin
      #500000;
      n_errors++;
      conclude();
   end
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      {reg_wr, reg_rd, boundary_en, ret_req} = 4'h0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      peri_event = 8'h00;
      ext_pin = 3'h0;
      port_pin = 4'h0;
      n_errors = 0;
      n_compared = 0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(icp_pkg::REG_CTRL, 8'h00);
      rd(icp_pkg::REG_CORE_PRIO, 8'h0f);
      rd(icp_pkg::REG_EDGE, 8'h07);
      rd(icp_pkg::REG_PERI_PRIO, 8'hff);
      rd(icp_pkg::REG_STATUS, 8'h00);
      wr(4'ha, 8'h5a);
      rd(4'ha, 8'h00);
      // Compatibility mode, flag polled with every enable off.
      ev(8'h01);
      rd(icp_pkg::REG_PERI_FLAG, 8'h01);
      wr(icp_pkg::REG_PERI_PRIO, 8'h00);
      wr(icp_pkg::REG_PERI_EN, 8'h01);
      wr(icp_pkg::REG_CTRL, 8'h02);
      boundary_en <= 1'b1;
      none(5);
      boundary_en <= 1'b0;
      wr(icp_pkg::REG_CTRL, 8'h06);
      none(4);
      boundary_en <= 1'b1;
      take(16'h0008, 4);
      rd(icp_pkg::REG_CTRL, 8'h04);
      rd(icp_pkg::REG_STATUS, 8'h01);
      wr(icp_pkg::REG_PERI_FLAG, 8'h00);
      ret();
      rd(icp_pkg::REG_CTRL, 8'h06);
      rd(icp_pkg::REG_STATUS, 8'h00);
      // Priority mode: source 1 high, source 0 low.
      wr(icp_pkg::REG_PERI_PRIO, 8'h02);
      wr(icp_pkg::REG_PERI_EN, 8'h03);
      wr(icp_pkg::REG_CTRL, 8'h07);
      ev(8'h03);
      take(16'h0008, 4);
      rd(icp_pkg::REG_CTRL, 8'h05);
      wr(icp_pkg::REG_PERI_FLAG, 8'h01);
      wr(icp_pkg::REG_CTRL, 8'h07);
      none(6);
      ret();
      take(16'h0018, 4);
      rd(icp_pkg::REG_CTRL, 8'h03);
      rd(icp_pkg::REG_STATUS, 8'h02);
      ev(8'h02);
      take(16'h0008, 4);
      rd(icp_pkg::REG_STATUS, 8'h03);
      wr(icp_pkg::REG_PERI_FLAG, 8'h00);
      ret();
      rd(icp_pkg::REG_CTRL, 8'h03);
      rd(icp_pkg::REG_STATUS, 8'h02);
      ret();
      rd(icp_pkg::REG_CTRL, 8'h07);
      rd(icp_pkg::REG_STATUS, 8'h00);
      // Global enables of both levels.
      wr(icp_pkg::REG_CTRL, 8'h05);
      ev(8'h03);
      none(5);
      wr(icp_pkg::REG_PERI_FLAG, 8'h01);
      wr(icp_pkg::REG_CTRL, 8'h03);
      none(5);
      wr(icp_pkg::REG_CTRL, 8'h07);
      take(16'h0018, 4);
      wr(icp_pkg::REG_PERI_FLAG, 8'h00);
      ret();
      // External pin on the falling edge, compatibility mode.
      wr(icp_pkg::REG_PERI_EN, 8'h00);
      wr(icp_pkg::REG_CTRL, 8'h02);
      wr(icp_pkg::REG_EDGE, 8'h06);
      wr(icp_pkg::REG_CORE_EN, 8'h01);
      @(posedge clk);
      ext_pin <= 3'h1;
      none(6);
      ext_pin <= 3'h0;
      take(16'h0008, 6);
      rd(icp_pkg::REG_CORE_FLAG, 8'h01);
      wr(icp_pkg::REG_CORE_FLAG, 8'h00);
      ret();
      // Port change keeps flagging until the port is read.
      @(posedge clk);
      port_pin <= 4'h1;
      none(5);
      rd(icp_pkg::REG_CORE_FLAG, 8'h08);
      wr(icp_pkg::REG_CORE_FLAG, 8'h00);
      rd(icp_pkg::REG_CORE_FLAG, 8'h08);
      rd(icp_pkg::REG_PORT, 8'h01);
      wr(icp_pkg::REG_CORE_FLAG, 8'h00);
      rd(icp_pkg::REG_CORE_FLAG, 8'h00);
      conclude();
   end
endmodule : tb_icp_ctrl
